/* core/scru_pkg.sv */
package scru_pkg;

  // ------------------------------------------------------------------
  // Unit clock ratio encoding
  // ------------------------------------------------------------------

  // Clock ratio of a gated unit, relative to the system bus clock.
  typedef enum logic [1:0] {
    RATIO_OFF   = 2'b00,
    RATIO_FULL  = 2'b01,
    RATIO_HALF  = 2'b10,
    RATIO_THIRD = 2'b11
  } scru_ratio_t;

  // ------------------------------------------------------------------
  // Register map and reset values
  // ------------------------------------------------------------------

  localparam logic [7:0]  OCC_OFF      = 8'h00;   // Output clock control.
  localparam logic [7:0]  SCC_OFF      = 8'h04;   // System clock control.
  localparam logic [7:0]  LBC_OFF      = 8'h08;   // Local bus clock control.
  localparam logic [7:0]  CFG_OFF      = 8'h0c;   // Captured configuration, read only.
  localparam logic [7:0]  RATE_OFF     = 8'h10;   // Derived clock ratios, read only.
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;    // Only whole-word writes are honoured.
  localparam int          NUM_BUS_OUT  = 5;       // Bus clock outputs.
  localparam int          NUM_UNITS    = 5;       // Units with four ratio choices.
  localparam int          SCC_FIELD_W  = 2;       // Width of one unit ratio field.
  localparam int          SCC_PCI_BIT  = 10;      // Bus interfaces and DMA clock on.
  localparam logic [4:0]  OCC_RST      = 5'h00;   // All bus outputs undivided.
  localparam logic [10:0] SCC_RST      = 11'h7ff; // Units at one third, bus and DMA on.
  localparam logic [1:0]  LBC_RST      = 2'h0;    // Local bus divide by two.

  // ------------------------------------------------------------------
  // Low reset configuration word layout
  // ------------------------------------------------------------------

  localparam int          RCW_LB_BIT   = 0;       // Local bus ratio bit.
  localparam int          RCW_MEM_BIT  = 1;       // Memory ratio bit.
  localparam int          RCW_SYSTEM_PLL_FACTOR_LSB = 4;       // System PLL factor, four bits.
  localparam int          RCW_CORE_LSB = 8;       // Core PLL factor, four bits.
  localparam logic [31:0] HARD_RCW     = 32'h0000_0240; // Built-in reset option.

  // Decodes the system PLL factor; zero stands for sixteen, one for the reserved code.
  function automatic logic [4:0] system_pll_factor_mult(input logic [3:0] f);
    if (f == 4'h0) begin
      return 5'h10;
    end else if (f == 4'h1) begin
      return 5'h00;
    end else begin
      return {1'b0, f};
    end
  endfunction

  // Half period of the local bus clock in local bus internal ticks.
  function automatic logic [2:0] lb_half(input logic [1:0] d);
    case (d)
      2'h0:    return 3'h1;
      2'h1:    return 3'h2;
      default: return 3'h4;
    endcase
  endfunction

  // Period of a unit clock in system bus clock ticks.
  function automatic logic [1:0] ratio_period(input scru_ratio_t r);
    case (r)
      RATIO_HALF:  return 2'h2;
      RATIO_THIRD: return 2'h3;
      default:     return 2'h1;
    endcase
  endfunction

endpackage

/* core/scru_unit_div.sv */
`timescale 1ns/10ps
module scru_unit_div #(
  parameter scru_pkg::scru_ratio_t RESET_RATIO = scru_pkg::RATIO_THIRD
) (
  input  logic                  clock,
  input  logic                  rst,
  input  logic                  csb_tick,
  input  scru_pkg::scru_ratio_t ratio_req,
  output logic                  unit_tick
);
  import scru_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------

  // Active ratio, ticks left in the current period, and the tick output.
  typedef struct packed {
    scru_ratio_t act;
    logic [1:0]  cnt;
    logic        tick;
  } scru_div_state_t;

  scru_div_state_t s_reg;   // Registered state.
  scru_div_state_t s_next;  // Next state.

  // A new ratio is only taken at the end of a whole period, so that the
  // unit never sees a shortened clock pulse.
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (csb_tick) begin
      if (s_reg.cnt == 2'h0) begin
        s_next.act  = ratio_req;                           // [RL17]
        s_next.tick = (ratio_req != RATIO_OFF);            // [RL12] [RL13]
        s_next.cnt  = ratio_period(ratio_req) - 2'h1;
      end else begin
        s_next.cnt = s_reg.cnt - 2'h1;
      end
    end
    if (rst) begin
      s_next.act  = RESET_RATIO;
      s_next.cnt  = 2'h0;
      s_next.tick = 1'b0;
    end
  end

  // Registers the state on every edge.
  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  assign unit_tick = s_reg.tick;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_quiet5;
    !unit_tick [*5];
  endsequence

  property p_off_quiet;
    s_reg.act == RATIO_OFF && ratio_req == RATIO_OFF |=> !unit_tick;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("Unit clock ran while off."); // [RL12]

  property p_third_gap;
    unit_tick && s_reg.act == RATIO_THIRD |=> s_quiet5;
  endproperty
  a_third_gap: assert property (p_third_gap) else $error("Third-rate tick came early."); // [RL17]

  property p_full_pace;
    unit_tick && s_reg.act == RATIO_FULL ##1 ratio_req == RATIO_FULL |=> unit_tick;
  endproperty
  a_full_pace: assert property (p_full_pace) else $error("Full-rate tick missing."); // [RL13]

endmodule

/* core/scru_top.sv */
`timescale 1ns/10ps
// Overview of operation
// RL1 - Primary reference follows host or agent mode.
// RL2 - Host reference feeds divide-by-two and muxes.
// RL3 - Input divide strap picks sync output rate.
// RL4 - Each bus clock output has divide select.
// RL5 - Bus ratio is one-plus-strap times PLL factor.
// RL6 - Core ratio multiplies bus ratio by core factor.
// RL7 - PLL factors come from reset word or option.
// RL8 - Memory clock ratio bit, then divide by two.
// RL9 - Memory data rate equals memory internal clock.
// RL10 - Local bus internal clock is 1x or 2x.
// RL11 - Local bus outputs divide by 2, 4, 8.
// RL12 - Four-choice units default to one third rate.
// RL13 - Bus interfaces and DMA: full rate or off.
// RL14 - Software keeps security and USB under maximum.
// RL15 - Configuration keeps derived clocks within range.
// RL16 - Factor 0000 means sixteen, 0001 reserved.
// RL17 - Ratio changes never glitch a unit clock.
module scru_top (
  input  logic                         clock,
  input  logic                         rst,
  input  logic                         hsel,
  input  logic [31:0]                  haddr,
  input  logic [1:0]                   htrans,
  input  logic                         hwrite,
  input  logic [2:0]                   hsize,
  input  logic                         hready,
  input  logic [31:0]                  hwdata,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  logic                         host_mode_strap,
  input  logic                         input_divide_strap,
  input  logic                         hard_coded_select,
  input  logic [31:0]                  low_reset_config_word,
  input  logic                         host_reference_input,
  input  logic                         agent_clock_input,
  output logic                         primary_reference_output,
  output logic                         pci_sync_output,
  output logic [scru_pkg::NUM_BUS_OUT-1:0] bus_clock_output_n,
  output logic                         system_bus_clock_output,
  output logic                         memory_bus_clock_pair_p,
  output logic                         memory_bus_clock_pair_n,
  output logic                         memory_data_tick,
  output logic                         local_bus_sync_output,
  output logic [2:0]                   local_bus_clock_outputs,
  output logic [scru_pkg::NUM_UNITS-1:0]   unit_clock_tick,
  output logic                         pci_dma_clock_tick
);
  import scru_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------

  // Every flip-flop of the block, other than those inside the unit dividers, lives in this one record.
  typedef struct packed {
    logic [NUM_BUS_OUT-1:0] occ;        // Bus output divide selects.
    logic [10:0]            scc;        // Unit ratio fields and bus/DMA enable.
    logic [1:0]             lbc;        // Local bus divider field.
    logic                   host_mode;  // Captured host or agent mode.
    logic                   div_strap;  // Captured input divide strap.
    logic [3:0]             system_pll_factor;       // System PLL factor.
    logic [3:0]             core_pll_factor;    // Core PLL factor.
    logic                   mem_bit;    // Memory ratio bit.
    logic                   lb_bit;     // Local bus ratio bit.
    logic [5:0]             csb_ratio;  // Bus clock to sync input ratio.
    logic [9:0]             core_ratio; // Core clock to sync input ratio.
    logic                   ref_q;      // Sampled host reference.
    logic                   half;       // Host reference divided by two.
    logic                   primary;    // Selected primary reference.
    logic                   sync_out;   // Sync output level.
    logic [NUM_BUS_OUT-1:0] bus_out;    // Bus clock output levels.
    logic                   csb_phase;  // System bus clock level.
    logic                   ddr_tick;   // Memory data transfer strobe.
    logic                   mem_p;      // Memory clock, true side.
    logic                   mem_n;      // Memory clock, complement side.
    logic [2:0]             lb_cnt;     // Ticks in the current half period.
    logic [2:0]             lb_half;    // Active half period.
    logic                   lb_clk;     // Local bus clock level.
    logic                   wr_pend;    // Write data phase pending.
    logic [7:0]             addr;       // Latched register offset.
    logic [31:0]            rdata;      // Read data.
    logic                   ready;      // Ready output.
    logic                   resp;       // Response output.
  } scru_state_t;

  scru_state_t s_reg;        // Registered state.
  scru_state_t s_next;       // Next state.
  logic        accept;       // Address phase taken this cycle.
  logic        map_ok;       // Upper address bits are zero.
  logic        ddr_tick;     // Memory internal clock tick.
  logic        lbiu_tick;    // Local bus internal clock tick.
  logic [31:0] rcw;          // Reset word in force.

  // Bus clock tick: the block clock runs at twice the system bus clock,
  // so the memory and local bus clocks can take the doubled ratio.
  logic csb_tick;
  assign csb_tick = s_reg.csb_phase;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------

  // Computes every next value; reset overrides at the end.
  always_comb begin
    s_next           = s_reg;
    s_next.csb_phase = ~s_reg.csb_phase;

    // Host reference path and primary selection.
    s_next.ref_q   = host_reference_input;
    if (s_reg.host_mode && host_reference_input && !s_reg.ref_q) begin
      s_next.half = ~s_reg.half;                                      // [RL2]
    end
    s_next.primary = s_reg.host_mode ? host_reference_input : agent_clock_input; // [RL1]
    s_next.sync_out = s_reg.host_mode & (s_reg.div_strap ? s_reg.half : s_reg.ref_q); // [RL3]
    for (int i = 0; i < NUM_BUS_OUT; i++) begin
      s_next.bus_out[i] = s_reg.host_mode & (s_reg.occ[i] ? s_reg.half : s_reg.ref_q); // [RL4]
    end

    // Derived ratios; the reserved factor reads as zero.
    s_next.csb_ratio  = (s_reg.div_strap ? 6'h2 : 6'h1) * {1'b0, system_pll_factor_mult(s_reg.system_pll_factor)}; // [RL5] [RL16]
    s_next.core_ratio = {4'h0, s_reg.csb_ratio} * {6'h0, s_reg.core_pll_factor};            // [RL6]

    // Memory clock: ticks at one or two times the bus clock.
    ddr_tick        = s_reg.mem_bit | csb_tick;                       // [RL8]
    s_next.ddr_tick = ddr_tick;                                       // [RL9]
    if (ddr_tick) begin
      s_next.mem_p = ~s_reg.mem_p;                                    // [RL8]
      s_next.mem_n = s_reg.mem_p;
    end

    // Local bus clock: a new divider is taken only at a toggle.
    lbiu_tick = s_reg.lb_bit | csb_tick;                              // [RL10]
    if (lbiu_tick) begin
      if (s_reg.lb_cnt == s_reg.lb_half - 3'h1) begin
        s_next.lb_clk  = ~s_reg.lb_clk;                               // [RL11]
        s_next.lb_cnt  = 3'h0;
        s_next.lb_half = lb_half(s_reg.lbc);
      end else begin
        s_next.lb_cnt = s_reg.lb_cnt + 3'h1;
      end
    end

    // Bus slave: writes land in the data phase.
    if (s_reg.wr_pend) begin
      case (s_reg.addr)
        OCC_OFF: begin
          s_next.occ = hwdata[NUM_BUS_OUT-1:0];
        end
        SCC_OFF: begin
          s_next.scc = hwdata[10:0];
        end
        LBC_OFF: begin
          s_next.lbc = hwdata[1:0];
        end
        default: begin
          s_next.occ = s_next.occ;
        end
      endcase
    end

    // Address phase: reads see a write that lands in the same cycle.
    map_ok         = (haddr[31:8] == 24'h0);
    accept         = hsel & htrans[1] & hready;
    s_next.wr_pend = accept & hwrite & (hsize == HSIZE_WORD) & map_ok;
    if (accept) begin
      s_next.addr = haddr[7:0];
    end
    if (accept && !hwrite) begin
      s_next.rdata = 32'h0;
      if (map_ok) begin
        case (haddr[7:0])
          OCC_OFF: begin
            s_next.rdata = {27'h0, s_next.occ};
          end
          SCC_OFF: begin
            s_next.rdata = {21'h0, s_next.scc};
          end
          LBC_OFF: begin
            s_next.rdata = {30'h0, s_next.lbc};
          end
          CFG_OFF: begin
            s_next.rdata = {19'h0, s_reg.system_pll_factor == 4'h1, s_reg.lb_bit, s_reg.mem_bit,
                            s_reg.host_mode, s_reg.div_strap, s_reg.core_pll_factor, s_reg.system_pll_factor};
          end
          RATE_OFF: begin
            s_next.rdata = {6'h0, s_reg.core_ratio, 10'h0, s_reg.csb_ratio};
          end
          default: begin
            s_next.rdata = 32'h0;
          end
        endcase
      end
    end
    s_next.ready = 1'b1;
    s_next.resp  = 1'b0;

    // Synchronous reset; straps and the reset word are caught here.
    rcw = hard_coded_select ? HARD_RCW : low_reset_config_word;
    if (rst) begin
      s_next           = '0;
      s_next.scc       = SCC_RST;
      s_next.occ       = OCC_RST;
      s_next.lbc       = LBC_RST;
      s_next.lb_half   = 3'h1;
      s_next.mem_n     = 1'b1;
      s_next.ready     = 1'b1;
      s_next.host_mode = host_mode_strap;
      s_next.div_strap = input_divide_strap;
      s_next.system_pll_factor      = rcw[RCW_SYSTEM_PLL_FACTOR_LSB +: 4];                      // [RL7]
      s_next.core_pll_factor   = rcw[RCW_CORE_LSB +: 4];                      // [RL7]
      s_next.mem_bit   = rcw[RCW_MEM_BIT];
      s_next.lb_bit    = rcw[RCW_LB_BIT];
    end
  end

  // Registers the whole state on every edge.
  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  // ------------------------------------------------------------------
  // Unit clock dividers
  // ------------------------------------------------------------------

  // One divider per four-choice unit, fed from its ratio field.
  for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
    scru_unit_div #(
      .RESET_RATIO (RATIO_THIRD)
    ) u_div (
      .clock     (clock),
      .rst       (rst),
      .csb_tick  (csb_tick),
      .ratio_req (scru_ratio_t'(s_reg.scc[g*SCC_FIELD_W +: SCC_FIELD_W])), // [RL12]
      .unit_tick (unit_clock_tick[g])
    );
  end

  // Bus interfaces and DMA: full rate or off only.
  scru_unit_div #(
    .RESET_RATIO (RATIO_FULL)
  ) u_pci_div (
    .clock     (clock),
    .rst       (rst),
    .csb_tick  (csb_tick),
    .ratio_req (s_reg.scc[SCC_PCI_BIT] ? RATIO_FULL : RATIO_OFF),     // [RL13]
    .unit_tick (pci_dma_clock_tick)
  );

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------

  assign hrdata                   = s_reg.rdata;
  assign hreadyout                = s_reg.ready;
  assign hresp                    = s_reg.resp;
  assign primary_reference_output = s_reg.primary;
  assign pci_sync_output          = s_reg.sync_out;
  assign bus_clock_output_n       = s_reg.bus_out;
  assign system_bus_clock_output  = s_reg.csb_phase;
  assign memory_bus_clock_pair_p  = s_reg.mem_p;
  assign memory_bus_clock_pair_n  = s_reg.mem_n;
  assign memory_data_tick         = s_reg.ddr_tick;
  assign local_bus_sync_output    = s_reg.lb_clk;
  assign local_bus_clock_outputs  = {3{s_reg.lb_clk}};

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_primary_select;
    1'b1 |=> primary_reference_output == ($past(s_reg.host_mode) ?
             $past(host_reference_input) : $past(agent_clock_input));
  endproperty
  a_primary_select: assert property (p_primary_select) else $error("Wrong primary."); // [RL1]

  property p_half_toggle;
    s_reg.host_mode && host_reference_input && !s_reg.ref_q |=> $changed(s_reg.half);
  endproperty
  a_half_toggle: assert property (p_half_toggle) else $error("Divider missed an edge."); // [RL2]

  property p_sync_mux;
    s_reg.host_mode |=> pci_sync_output ==
                        ($past(s_reg.div_strap) ? $past(s_reg.half) : $past(s_reg.ref_q));
  endproperty
  a_sync_mux: assert property (p_sync_mux) else $error("Sync output wrong source."); // [RL3]

  property p_bus_div;
    s_reg.host_mode && s_reg.occ[0] |=> bus_clock_output_n[0] == $past(s_reg.half);
  endproperty
  a_bus_div: assert property (p_bus_div) else $error("Bus clock output not divided."); // [RL4]

  property p_csb_ratio;
    s_reg.div_strap && s_reg.system_pll_factor == 4'h0 |=> s_reg.csb_ratio == 6'h20;
  endproperty
  a_csb_ratio: assert property (p_csb_ratio) else $error("Bus ratio wrong."); // [RL5]

  property p_system_pll_factor_reserved;
    s_reg.system_pll_factor == 4'h1 |=> s_reg.csb_ratio == 6'h0;
  endproperty
  a_system_pll_factor_reserved: assert property (p_system_pll_factor_reserved) else $error("Reserved factor used."); // [RL16]

  property p_core_ratio;
    1'b1 |=> s_reg.core_ratio == $past(s_reg.csb_ratio) * $past(s_reg.core_pll_factor);
  endproperty
  a_core_ratio: assert property (p_core_ratio) else $error("Core ratio wrong."); // [RL6]

  property p_mem_pair;
    s_reg.mem_bit |=> $changed(memory_bus_clock_pair_p) &&
                      memory_bus_clock_pair_n == !memory_bus_clock_pair_p;
  endproperty
  a_mem_pair: assert property (p_mem_pair) else $error("Memory clock pair wrong."); // [RL8]

  sequence s_one_strobe;
    memory_data_tick ##1 !memory_data_tick;
  endsequence

  property p_mem_rate;
    !s_reg.mem_bit && csb_tick |=> s_one_strobe;
  endproperty
  a_mem_rate: assert property (p_mem_rate) else $error("Memory strobe rate wrong."); // [RL9]

  property p_lb_ratio;
    !s_reg.lb_bit && !csb_tick |=> $stable(local_bus_sync_output);
  endproperty
  a_lb_ratio: assert property (p_lb_ratio) else $error("Local bus ran too fast."); // [RL10]

  property p_lb_div4;
    $changed(local_bus_sync_output) && !s_reg.lb_bit && s_reg.lb_half == 3'h2
      |=> $stable(local_bus_sync_output) [*3];
  endproperty
  a_lb_div4: assert property (p_lb_div4) else $error("Local bus divide wrong."); // [RL11]

endmodule

/* verification/scru_clk_src.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Reference sources: a free running oscillator and a bus clock
// ------------------------------------------------------------------
module scru_clk_src #(
  parameter int HOST_HALF  = 2, // Block cycles per oscillator half period.
  parameter int AGENT_HALF = 3  // Block cycles per bus clock half period.
) (
  input  logic clock,
  output logic host_ref,
  output logic agent_ref
);
  int hcnt = 0; // Oscillator phase counter.
  int acnt = 0; // Bus clock phase counter.
  initial begin
    host_ref = 1'b0;
    agent_ref = 1'b0;
  end
  // Both run free at fixed in-range rates, changing just after each edge.
  always @(posedge clock) begin
    hcnt <= (hcnt == HOST_HALF - 1) ? 0 : hcnt + 1;
    acnt <= (acnt == AGENT_HALF - 1) ? 0 : acnt + 1;
    if (hcnt == HOST_HALF - 1) host_ref <= ~host_ref;
    if (acnt == AGENT_HALF - 1) agent_ref <= ~agent_ref;
  end
endmodule

/* verification/system_clock_ratio_unit_tb.sv */
`timescale 1ns/10ps
module system_clock_ratio_unit_tb;
  import scru_pkg::*;
  logic        clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        host = 1'b1, divs = 1'b0, hard = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, word = '0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, host_ref, agent_ref, prim, sync, sbc, mp, mn, mtick, lsync, dtick;
  logic [4:0]  bco, utick;
  logic [2:0]  lclk;
  logic        psbc;     // System bus clock level at the last edge.
  logic [8:0]  lv, pv;   // Watched levels and their copy from the last edge.
  int          cnt [17]; // Rising edges, tick pulses, and output mismatches.
  int          error_cnt = 0, n_checks = 0, cyc = 0;
  // Per run: straps and reset word, expected reads, register values, counts.
  logic [34:0] cfg [3] = '{{3'b110, 32'h302}, {3'b000, 32'h211}, {3'b101, 32'hffff}};
  logic [31:0] r0c [3] = '{32'h730, 32'h1821, 32'h224};
  logic [31:0] r10 [3] = '{32'h0060_0020, 32'h0, 32'h0008_0004};
  logic [31:0] sccv [3] = '{32'h7ff, 32'h1e4, 32'h49b};
  logic [31:0] lbcv [3] = '{32'h2, 32'h1, 32'h0};
  int ex [3][17] = '{'{60,30,60,30,60,30,60,120,15,240,40,40,40,40,40,120,0},
                     '{40,0,0,0,0,0,0,60,60,120,0,120,60,40,120,0,0},
                     '{60,60,60,30,60,30,60,60,60,120,40,60,120,60,0,120,0}};

  always #25 clock = ~clock;

  scru_clk_src i_scru_clk_src (.clock(clock), .host_ref(host_ref), .agent_ref(agent_ref));

  scru_top i_scru_top (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .host_mode_strap(host), .input_divide_strap(divs), .hard_coded_select(hard),
    .low_reset_config_word(word), .host_reference_input(host_ref),
    .agent_clock_input(agent_ref), .primary_reference_output(prim),
    .pci_sync_output(sync), .bus_clock_output_n(bco), .system_bus_clock_output(sbc),
    .memory_bus_clock_pair_p(mp), .memory_bus_clock_pair_n(mn),
    .memory_data_tick(mtick), .local_bus_sync_output(lsync),
    .local_bus_clock_outputs(lclk), .unit_clock_tick(utick),
    .pci_dma_clock_tick(dtick)
  );

  // ------------------------------------------------------------------
  // Clock monitor: counts edges and pulses over a measuring window
  // ------------------------------------------------------------------
  assign lv = {lsync, mp, bco, sync, prim};
  always @(posedge clock) begin
    pv <= lv;
    for (int i = 0; i < 9; i++) if (lv[i] === 1'b1 && pv[i] === 1'b0) cnt[i]++;
    cnt[9] += (mtick === 1'b1);
    for (int i = 0; i < 5; i++) cnt[10+i] += (utick[i] === 1'b1);
    cnt[15] += (dtick === 1'b1);
    psbc <= sbc;
    // Local bus copies, bus clock toggling, memory pair and OKAY response.
    if (lclk !== {3{lsync}} || sbc === psbc || mn !== ~mp || hresp !== 1'b0) cnt[16]++;
  end

  // ------------------------------------------------------------------
  // Bus access, comparison and closing report
  // ------------------------------------------------------------------
  // One single-word transfer; starts just after an edge, waits on ready.
  task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= HSIZE_WORD;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // Compares a value seen with the expected one, within a tolerance.
  task automatic check(input logic [31:0] seen, exp, input int tol);
    n_checks++;
    if (!(seen === exp || ((seen + tol >= exp) === 1'b1 && (seen <= exp + tol) === 1'b1))) begin
      error_cnt++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang is cut short well after the expected run of about 830 cycles.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence: one reset and one measuring window per configuration
  // ------------------------------------------------------------------
  initial begin
    for (int c = 0; c < 3; c++) begin
      {host, divs, hard, word} <= cfg[c];
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      bus(1'b0, SCC_OFF, '0, rd);
      check(rd, 32'h7ff, 0);
      bus(1'b0, OCC_OFF, '0, rd);
      check(rd, 32'h0, 0);
      bus(1'b0, 32'h20, '0, rd);
      check(rd, 32'h0, 0);
      bus(1'b0, CFG_OFF, '0, rd);
      check(rd, r0c[c], 0);
      bus(1'b0, RATE_OFF, '0, rd);
      check(rd, r10[c], 0);
      bus(1'b1, OCC_OFF, 32'hffff_ffea, rd);
      bus(1'b1, LBC_OFF, lbcv[c], rd);
      // Security and USB fields stay at or below their rate limit.
      bus(1'b1, SCC_OFF, sccv[c], rd);
      bus(1'b0, SCC_OFF, '0, rd);
      check(rd, sccv[c], 0);
      bus(1'b0, OCC_OFF, '0, rd);
      check(rd, 32'h0a, 0);
      // Let the new ratios reach a period end before measuring.
      repeat (12) @(posedge clock);
      #1;
      cnt = '{default: 0};
      repeat (240) @(posedge clock);
      #1;
      for (int i = 0; i < 17; i++) begin
        check(cnt[i], ex[c][i], 1);
      end
      $display("test %0d done", c);
      @(posedge clock);
    end
    summarize();
  end
endmodule
